// [src/sccl_clock_ctrl.sv]
// Purpose: system clock controller: source switch, prescalers, gating, monitors, clock outputs
// Assumes: AHB-Lite slave, one sys_clk domain; oscillator clocks and ready lines arrive asynchronously
// Notes: clock muxes and gate cells sit outside; this block drives their selects and enables
//
// Design decisions made here: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps
module sccl_clock_ctrl #(
    parameter int LSE_LOSS_CYC = sccl_pkg::LSE_LOSS_CYC
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [sccl_pkg::RDY_W-1:0] osc_rdy_raw,
    input wire logic [sccl_pkg::CLK_W-1:0] osc_clk_raw,
    input wire logic low_power,
    input wire logic vbat_only,
    output sccl_pkg::sccl_osc_type osc_ctl,
    output sccl_pkg::sccl_trim_type osc_trim,
    output sccl_pkg::sccl_src_type pll_src,
    output logic [2:0] pll_on,
    output logic [8:0] pll_out_en,
    output sccl_pkg::sccl_src_type sys_src_sel,
    output logic sys_gate_en,
    output logic cpu_tick,
    output logic apb1_tick,
    output logic apb2_tick,
    output logic [15:0] kclk_sel,
    output logic [31:0] clk_gate_en,
    output logic mco_out,
    output logic slow_clock_output_out,
    output logic clk_irq
);
    typedef struct packed {
        logic [sccl_pkg::ADDR_W-1:0] addr;
        logic wr_ph;
        logic rd_ph;
        logic [31:0] rdata;
        sccl_pkg::sccl_osc_type osc;
        sccl_pkg::sccl_cfg_type cfg;
        sccl_pkg::sccl_trim_type trim;
        sccl_pkg::sccl_pll_type pll;
        logic [8:0] pll_oe;
        logic [15:0] ksel;
        logic [31:0] grun;
        logic [31:0] gslp;
        logic [31:0] gate;
        logic [1:0] ie;
        logic [1:0] flag;
        sccl_pkg::sccl_sw_state_type fsm;
        sccl_pkg::sccl_src_type cur;
        sccl_pkg::sccl_src_type tgt;
        logic [3:0] gap;
        logic gate_off;
        logic [sccl_pkg::DIV_W-1:0] div;
        logic [2:0] ticks;
        logic [10:0] at_cnt;
        logic clock_output_pin;
        logic slow_clock_output;
    } sccl_state_type;

    sccl_state_type q;
    sccl_state_type n;
    logic [sccl_pkg::RDY_W-1:0] rdy;
    logic [sccl_pkg::CLK_W-1:0] clk_lvl;
    logic [sccl_pkg::CLK_W-1:0] clk_rise;
    logic [sccl_pkg::RDY_W-1:0] rdy_rise_unused;
    logic hse_lost;
    logic lse_lost;
    logic hse_watch_en;
    logic lse_watch_en;

    // Ready lines and raw oscillator clocks share one synchroniser bank
    sccl_sync3 #(
        .W(sccl_pkg::RDY_W + sccl_pkg::CLK_W)
    ) u_sync (
        .sys_clk(sys_clk),
        .srst(srst),
        .din({osc_clk_raw, osc_rdy_raw}),
        .level({clk_lvl, rdy}),
        .rise({clk_rise, rdy_rise_unused})
    );

    assign hse_watch_en = q.osc.css_hse_en & q.osc.hse_on & rdy[sccl_pkg::RDY_HSE];
    assign lse_watch_en = q.osc.css_lse_en & q.osc.lse_on & rdy[sccl_pkg::RDY_LSE];

    sccl_loss_watch #(
        .LIMIT(sccl_pkg::HSE_LOSS_CYC)
    ) u_hse_watch (
        .sys_clk(sys_clk),
        .srst(srst),
        .enable(hse_watch_en),
        .edge_seen(clk_rise[sccl_pkg::CLK_HSE]),
        .lost(hse_lost)
    );

    sccl_loss_watch #(
        .LIMIT(LSE_LOSS_CYC)
    ) u_lse_watch (
        .sys_clk(sys_clk),
        .srst(srst),
        .enable(lse_watch_en),
        .edge_seen(clk_rise[sccl_pkg::CLK_LSE]),
        .lost(lse_lost)
    );

    function automatic logic src_ready(input sccl_pkg::sccl_src_type s, input logic [sccl_pkg::RDY_W-1:0] r);
        case (s)
            sccl_pkg::SRC_MSI: return r[sccl_pkg::RDY_MSI];
            sccl_pkg::SRC_HSI: return r[sccl_pkg::RDY_HSI];
            sccl_pkg::SRC_HSE: return r[sccl_pkg::RDY_HSE];
            default: return r[sccl_pkg::RDY_PLL0];
        endcase
    endfunction

    always_comb begin
        logic [31:0] rd;
        logic [31:0] wd;
        logic hse_in_use;
        logic [3:0] apb1_exp;
        logic [3:0] apb2_exp;
        logic [10:0] target;
        sccl_pkg::sccl_cfg_type cfg_w;
        sccl_pkg::sccl_trim_type trim_w;
        sccl_pkg::sccl_pll_type pll_w;
        rd = '0;
        wd = hwdata;
        hse_in_use = 1'b0;
        apb1_exp = '0;
        apb2_exp = '0;
        target = '0;
        cfg_w = sccl_pkg::sccl_cfg_type'(wd[15:0]);
        trim_w = sccl_pkg::sccl_trim_type'(wd[19:0]);
        pll_w = sccl_pkg::sccl_pll_type'(wd[13:0]);
        n = q;
        n.wr_ph = 1'b0;
        n.rd_ph = 1'b0;

        // Register read mux, used in the first data-phase cycle
        case (q.addr)
            sccl_pkg::OFS_OSC: rd = 32'(q.osc);
            sccl_pkg::OFS_CFG: rd = 32'(q.cfg);
            sccl_pkg::OFS_TRIM: rd = 32'(q.trim);
            sccl_pkg::OFS_PLL: rd = 32'(q.pll);
            sccl_pkg::OFS_KSEL: rd = 32'(q.ksel);
            sccl_pkg::OFS_GRUN: rd = q.grun;
            sccl_pkg::OFS_GSLP: rd = q.gslp;
            sccl_pkg::OFS_INT: rd = 32'({q.ie, q.flag});
            sccl_pkg::OFS_STAT: rd = 32'({q.fsm != sccl_pkg::SW_IDLE, q.cur, rdy});
            default: rd = '0;
        endcase
        if (q.rd_ph) begin
            n.rdata = rd;
        end

        if (q.wr_ph) begin
            case (q.addr)
                sccl_pkg::OFS_OSC: n.osc = sccl_pkg::sccl_osc_type'(wd[11:0]);
                sccl_pkg::OFS_CFG: n.cfg = cfg_w;
                sccl_pkg::OFS_TRIM: begin
                    n.trim.hsi_trim = trim_w.hsi_trim;
                    n.trim.msi_trim = trim_w.msi_trim;
                    // Only twelve ranges exist; other codes are ignored
                    if (trim_w.msi_range < sccl_pkg::MSI_RANGES) begin
                        n.trim.msi_range = trim_w.msi_range;
                    end
                end
                sccl_pkg::OFS_PLL: begin
                    n.pll.on = pll_w.on;
                    n.pll.out_en = pll_w.out_en;
                    // PLL cannot reference itself; keep the old source
                    if (pll_w.src != sccl_pkg::SRC_PLL) begin
                        n.pll.src = pll_w.src;
                    end
                end
                sccl_pkg::OFS_KSEL: n.ksel = wd[15:0];
                sccl_pkg::OFS_GRUN: n.grun = wd;
                sccl_pkg::OFS_GSLP: n.gslp = wd;
                sccl_pkg::OFS_INT: n.ie = wd[3:2];
                default: ;
            endcase
        end

        if (hsel && htrans[1] && hready) begin
            n.addr = haddr[sccl_pkg::ADDR_W-1:0];
            n.wr_ph = hwrite;
            n.rd_ph = ~hwrite;
        end

        // Source switch: hold the old clock until the target is ready
        case (q.fsm)
            sccl_pkg::SW_IDLE: begin
                if (q.cfg.sw != q.cur) begin
                    n.tgt = q.cfg.sw;
                    n.fsm = sccl_pkg::SW_WAIT;
                end
            end
            sccl_pkg::SW_WAIT: begin
                if (q.cfg.sw != q.tgt) begin
                    n.tgt = q.cfg.sw;
                end else if (q.tgt == q.cur) begin
                    n.fsm = sccl_pkg::SW_IDLE;
                end else if (src_ready(q.tgt, rdy)) begin
                    n.gate_off = 1'b1;
                    n.gap = 4'(sccl_pkg::SWITCH_GAP_CYC);
                    n.fsm = sccl_pkg::SW_STOP;
                end
            end
            sccl_pkg::SW_STOP: begin
                // Switch FSM changes the mux only while the gated clock is stopped; the HSE-loss jump below changes it with the gate open
                if (q.gap == 4'h0) begin
                    n.cur = q.tgt;
                    n.gap = 4'(sccl_pkg::SWITCH_GAP_CYC);
                    n.fsm = sccl_pkg::SW_RESUME;
                end else begin
                    n.gap = q.gap - 4'h1;
                end
            end
            sccl_pkg::SW_RESUME: begin
                if (q.gap == 4'h0) begin
                    n.gate_off = 1'b0;
                    n.fsm = sccl_pkg::SW_IDLE;
                end else begin
                    n.gap = q.gap - 4'h1;
                end
            end
            default: begin
                n.gate_off = 1'b0;
                n.fsm = sccl_pkg::SW_IDLE;
            end
        endcase

        // Lost external oscillator: no clean handover is possible, jump at once
        hse_in_use = (q.cur == sccl_pkg::SRC_HSE) ||
                     (q.cur == sccl_pkg::SRC_PLL && q.pll.src == sccl_pkg::SRC_HSE);
        if (hse_lost && hse_in_use) begin
            n.cur = sccl_pkg::SRC_HSI;
            n.tgt = sccl_pkg::SRC_HSI;
            n.cfg.sw = sccl_pkg::SRC_HSI;
            n.osc.hsi_on = 1'b1;
            n.gate_off = 1'b0;
            n.fsm = sccl_pkg::SW_IDLE;
        end

        // Hardware set wins over a same-cycle clear
        if (q.wr_ph && q.addr == sccl_pkg::OFS_INT) begin
            n.flag = q.flag & ~wd[1:0];
        end
        if (hse_lost) begin
            n.flag[sccl_pkg::FLG_HSE] = 1'b1;
        end
        if (lse_lost) begin
            n.flag[sccl_pkg::FLG_LSE] = 1'b1;
        end

        // Auto-trim: count RC edges over one crystal period, nudge trim by one
        target = sccl_pkg::sccl_msi_target(q.trim.msi_range);
        if (q.osc.msi_autotrim && q.osc.msi_on && q.osc.lse_on && rdy[sccl_pkg::RDY_LSE]) begin
            if (clk_rise[sccl_pkg::CLK_LSE]) begin
                n.at_cnt = '0;
                if (q.at_cnt < target && q.trim.msi_trim != 8'hFF) begin
                    n.trim.msi_trim = q.trim.msi_trim + 8'h01;
                end else if (q.at_cnt > target && q.trim.msi_trim != 8'h00) begin
                    n.trim.msi_trim = q.trim.msi_trim - 8'h01;
                end
            end else if (clk_rise[sccl_pkg::CLK_MSI] && q.at_cnt != 11'h7FF) begin
                n.at_cnt = q.at_cnt + 11'h001;
            end
        end else begin
            n.at_cnt = '0;
        end

        // Prescalers as tick strobes; bus ratios stack on the CPU ratio
        n.div = q.div + 14'h0001;
        apb1_exp = 4'({1'b0, q.cfg.hpre} + {1'b0, q.cfg.ppre1});
        apb2_exp = 4'({1'b0, q.cfg.hpre} + {1'b0, q.cfg.ppre2});
        n.ticks[0] = (q.div & sccl_pkg::sccl_mask({1'b0, q.cfg.hpre})) == '0;
        n.ticks[1] = (q.div & sccl_pkg::sccl_mask(apb1_exp)) == '0;
        n.ticks[2] = (q.div & sccl_pkg::sccl_mask(apb2_exp)) == '0;

        for (int i = 0; i < 9; i++) begin
            n.pll_oe[i] = q.pll.out_en[i] & q.pll.on[i / 3] & rdy[sccl_pkg::RDY_PLL0 + i / 3];
        end

        n.gate = low_power ? q.gslp : q.grun;

        // Sampled copy: faithful only well below sys_clk / 2
        case (q.cfg.mco_sel)
            3'h1: n.clock_output_pin = clk_lvl[sccl_pkg::CLK_HSE];
            3'h2: n.clock_output_pin = clk_lvl[sccl_pkg::CLK_HSI];
            3'h3: n.clock_output_pin = clk_lvl[sccl_pkg::CLK_MSI];
            3'h4: n.clock_output_pin = clk_lvl[sccl_pkg::CLK_LSE];
            3'h5: n.clock_output_pin = clk_lvl[sccl_pkg::CLK_LSI];
            default: n.clock_output_pin = 1'b0;
        endcase
        if (q.cfg.slow_clock_output_en && !vbat_only) begin
            n.slow_clock_output = q.cfg.slow_clock_output_sel ? clk_lvl[sccl_pkg::CLK_LSE] : clk_lvl[sccl_pkg::CLK_LSI];
        end else begin
            n.slow_clock_output = 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            q <= '0;
            q.osc <= sccl_pkg::OSC_RST;
            q.cfg <= sccl_pkg::CFG_RST;
            q.trim <= sccl_pkg::TRIM_RST;
            q.pll <= sccl_pkg::PLL_RST;
            q.grun <= sccl_pkg::GRUN_RST;
            q.gslp <= sccl_pkg::GSLP_RST;
            q.gate <= sccl_pkg::GRUN_RST;
            q.cur <= sccl_pkg::SRC_MSI;
            q.tgt <= sccl_pkg::SRC_MSI;
            q.fsm <= sccl_pkg::SW_IDLE;
        end else begin
            q <= n;
        end
    end

    // Reads take one wait state so that hrdata comes from a flop
    assign hreadyout = ~q.rd_ph;
    assign hresp = 1'b0;
    assign hrdata = q.rdata;
    assign osc_ctl = q.osc;
    assign osc_trim = q.trim;
    assign pll_src = q.pll.src;
    assign pll_on = q.pll.on;
    assign pll_out_en = q.pll_oe;
    assign sys_src_sel = q.cur;
    assign sys_gate_en = ~q.gate_off;
    assign cpu_tick = q.ticks[0];
    assign apb1_tick = q.ticks[1];
    assign apb2_tick = q.ticks[2];
    assign kclk_sel = q.ksel;
    assign clk_gate_en = q.gate;
    assign mco_out = q.clock_output_pin;
    assign slow_clock_output_out = q.slow_clock_output;
    assign clk_irq = |(q.flag & q.ie);
endmodule

// [src/sccl_pkg.sv]
// Purpose: shared constants, types and register layouts of the system clock controller
// Assumes: 200 MHz sys_clk, AHB-Lite register port, analog oscillators and PLLs outside
// Notes: register layouts are packed structs, bit 0 is the last field listed
package sccl_pkg;

    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_OSC = 8'h00;
    localparam logic [7:0] OFS_CFG = 8'h04;
    localparam logic [7:0] OFS_TRIM = 8'h08;
    localparam logic [7:0] OFS_PLL = 8'h0C;
    localparam logic [7:0] OFS_KSEL = 8'h10;
    localparam logic [7:0] OFS_GRUN = 8'h14;
    localparam logic [7:0] OFS_GSLP = 8'h18;
    localparam logic [7:0] OFS_INT = 8'h1C;
    localparam logic [7:0] OFS_STAT = 8'h20;

    // Bit positions inside the synchronised ready and clock vectors and the flag field
    localparam int RDY_HSE = 0;
    localparam int RDY_HSI = 1;
    localparam int RDY_MSI = 2;
    localparam int RDY_LSE = 3;
    localparam int RDY_LSI = 4;
    localparam int RDY_PLL0 = 5;
    localparam int RDY_W = 8;
    localparam int CLK_HSE = 0;
    localparam int CLK_HSI = 1;
    localparam int CLK_MSI = 2;
    localparam int CLK_LSE = 3;
    localparam int CLK_LSI = 4;
    localparam int CLK_W = 5;
    localparam int FLG_HSE = 0;
    localparam int FLG_LSE = 1;

    localparam int CLK_MHZ = 200;
    localparam int HSE_LOSS_NS = 1000;
    localparam int HSE_LOSS_CYC = (HSE_LOSS_NS * CLK_MHZ + 999) / 1000;
    localparam int LSE_LOSS_US = 100;
    localparam int LSE_LOSS_CYC = LSE_LOSS_US * CLK_MHZ;
    localparam int SWITCH_GAP_NS = 20;
    localparam int SWITCH_GAP_CYC = (SWITCH_GAP_NS * CLK_MHZ + 999) / 1000;
    localparam int DIV_W = 14;
    localparam logic [3:0] MSI_RANGES = 4'hC;
    localparam logic [3:0] MSI_RANGE_4MHZ = 4'h6;
    localparam logic [7:0] TRIM_MID = 8'h80;
    localparam logic [31:0] GRUN_RST = 32'h0000_0001;
    localparam logic [31:0] GSLP_RST = 32'h0000_0000;

    typedef enum logic [1:0] {
        SRC_MSI = 2'h0,
        SRC_HSI = 2'h1,
        SRC_HSE = 2'h2,
        SRC_PLL = 2'h3
    } sccl_src_type;

    typedef enum logic [3:0] {
        SW_IDLE = 4'h1,
        SW_WAIT = 4'h2,
        SW_STOP = 4'h4,
        SW_RESUME = 4'h8
    } sccl_sw_state_type;

    typedef struct packed {
        logic css_lse_en;
        logic css_hse_en;
        logic msi_autotrim;
        logic lsi_on;
        logic [1:0] lse_drive;
        logic lse_byp;
        logic lse_on;
        logic msi_on;
        logic hsi_on;
        logic hse_byp;
        logic hse_on;
    } sccl_osc_type;

    typedef struct packed {
        logic slow_clock_output_en;
        logic slow_clock_output_sel;
        logic [2:0] mco_sel;
        logic [2:0] ppre2;
        logic [2:0] ppre1;
        logic [2:0] hpre;
        sccl_src_type sw;
    } sccl_cfg_type;

    typedef struct packed {
        logic [7:0] hsi_trim;
        logic [7:0] msi_trim;
        logic [3:0] msi_range;
    } sccl_trim_type;

    typedef struct packed {
        logic [8:0] out_en;
        logic [2:0] on;
        sccl_src_type src;
    } sccl_pll_type;

    localparam sccl_osc_type OSC_RST = '{msi_on: 1'b1, default: '0};
    localparam sccl_cfg_type CFG_RST = '{sw: SRC_MSI, default: '0};
    localparam sccl_trim_type TRIM_RST = '{hsi_trim: TRIM_MID, msi_trim: TRIM_MID, msi_range: MSI_RANGE_4MHZ};
    localparam sccl_pll_type PLL_RST = '{src: SRC_MSI, default: '0};

    // Multispeed RC edges expected in one 32.768 kHz period, per range
    function automatic logic [10:0] sccl_msi_target(input logic [3:0] range);
        case (range)
            4'h0: return 11'h003;
            4'h1: return 11'h006;
            4'h2: return 11'h00C;
            4'h3: return 11'h018;
            4'h4: return 11'h01F;
            4'h5: return 11'h03D;
            4'h6: return 11'h07A;
            4'h7: return 11'h0F4;
            4'h8: return 11'h1E8;
            4'h9: return 11'h2DC;
            4'hA: return 11'h3D1;
            default: return 11'h5B9;
        endcase
    endfunction

    function automatic logic [DIV_W-1:0] sccl_mask(input logic [3:0] exp2);
        return (14'h0001 << exp2) - 14'h0001;
    endfunction

endpackage

// [src/sccl_sync3.sv]
// Purpose: three-stage synchroniser with agreement filter and rise pulse
// Assumes: inputs asynchronous to sys_clk
// Notes: a change is taken once stages two and three agree
`timescale 1ns/1ps
module sccl_sync3 #(
    parameter int W = 1
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic [W-1:0] din,
    output logic [W-1:0] level,
    output logic [W-1:0] rise
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] lvl;
        logic [W-1:0] rise;
    } sccl_sync_type;

    sccl_sync_type q;
    sccl_sync_type n;
    logic [W-1:0] agree;

    always_comb begin
        n = q;
        agree = ~(q.s2 ^ q.s3);
        n.s1 = din;
        n.s2 = q.s1;
        n.s3 = q.s2;
        n.lvl = (agree & q.s3) | (~agree & q.lvl);
        n.rise = n.lvl & ~q.lvl;
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign level = q.lvl;
    assign rise = q.rise;
endmodule

// [src/sccl_loss_watch.sv]
// Purpose: flags a clock that shows no edge for LIMIT sys_clk cycles
// Assumes: edge_seen is a one-cycle pulse per edge of the watched clock
// Notes: lost pulses once per outage; rearms on the next edge
`timescale 1ns/1ps
module sccl_loss_watch #(
    parameter int LIMIT = 200
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic enable,
    input wire logic edge_seen,
    output logic lost
);
    localparam int CW = $clog2(LIMIT + 1);
    localparam logic [CW-1:0] LIM = CW'(LIMIT);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic lost;
    } sccl_watch_type;

    sccl_watch_type q;
    sccl_watch_type n;

    always_comb begin
        n = q;
        n.lost = 1'b0;
        if (!enable || edge_seen) begin
            n.cnt = '0;
        end else if (q.cnt != LIM) begin
            n.cnt = q.cnt + CW'(1);
            n.lost = (n.cnt == LIM);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign lost = q.lost;
endmodule

// [verif/sccl_osc_model.sv]
// Purpose: oscillator and PLL stand-in
// Assumes: a disabled source stops low
// Notes: rates shortened; slow ready for crystal and PLLs
`timescale 1ns/1ps
module sccl_osc_model #(
    parameter int RDY_NS = 300
) (
    input wire logic hse_stop,
    input wire sccl_pkg::sccl_osc_type ctl,
    input wire logic [2:0] pll_on,
    output logic [4:0] clk,
    output logic [7:0] rdy
);
    always #10 clk[0] = ctl.hse_on & ~hse_stop & ~clk[0];
    always #31 clk[1] = ctl.hsi_on & ~clk[1];
    always #125 clk[2] = ctl.msi_on & ~clk[2];
    always #500 clk[3] = ctl.lse_on & ~clk[3];
    always #600 clk[4] = ctl.lsi_on & ~clk[4];
    // Crystal ready stays up after a stall, as a real one may
    assign #50 rdy[4:1] = {ctl.lsi_on, ctl.lse_on, ctl.msi_on, ctl.hsi_on};
    assign #(RDY_NS) rdy[0] = ctl.hse_on;
    assign #(RDY_NS) rdy[7:5] = pll_on;
endmodule

// [verif/sccl_clock_ctrl_sva.sv]
// Purpose: port checks of the clock controller
// Assumes: bound to sccl_clock_ctrl
// Notes: one clock domain
`timescale 1ns/1ps
module sccl_clock_ctrl_sva (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic [sccl_pkg::RDY_W-1:0] osc_rdy_raw,
    input wire logic vbat_only,
    input wire logic [2:0] pll_on,
    input wire logic [8:0] pll_out_en,
    input wire sccl_pkg::sccl_src_type sys_src_sel,
    input wire logic sys_gate_en,
    input wire logic slow_clock_output_out
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    logic rd_take;
    assign rd_take = hsel && htrans[1] && hready && !hwrite;
    chk_read_wait: assert property (rd_take |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    chk_rdata_hold: assert property (!$stable(hrdata) |-> $past(rd_take, 2))
        else $error("read data moved without a read");
    chk_gate_low: assert property ($fell(sys_gate_en) |-> !sys_gate_en [*4])
        else $error("gate gap too short");
    chk_gate_back: assert property ($fell(sys_gate_en) |-> ##[1:20] sys_gate_en)
        else $error("gate not restored");
    chk_src_gated: assert property (!$stable(sys_src_sel) && sys_src_sel != sccl_pkg::SRC_HSI |-> !sys_gate_en)
        else $error("source moved with gate open");
    chk_pll_ready: assert property (!$stable(sys_src_sel) && sys_src_sel == sccl_pkg::SRC_PLL
        |-> $past(osc_rdy_raw[5], 3))
        else $error("switched to unready pll");
    chk_slow_clock_output_vbat: assert property ($past(vbat_only) |-> !slow_clock_output_out)
        else $error("slow output runs in battery mode");
    chk_pll_outs: assert property ((pll_out_en & ~{{3{$past(pll_on[2])}}, {3{$past(pll_on[1])}},
        {3{$past(pll_on[0])}}}) == 9'h000)
        else $error("pll output on without its pll");
endmodule

// [verif/sccl_clock_ctrl_test.sv]
// Purpose: self-checking bench of the clock controller
// Assumes: single AHB-Lite slave, oscillator stand-in
// Notes: LSE crystal loss limit shortened to 300
`timescale 1ns/1ps
module sccl_clock_ctrl_test;
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic low_power = 1'b0;
    logic vbat_only = 1'b0;
    logic hse_stop = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout, hresp, sys_gate_en, cpu_tick, apb1_tick, apb2_tick, mco_out, slow_clock_output_out, clk_irq;
    logic [31:0] hrdata, clk_gate_en, rd, wv;
    logic [2:0] pll_on;
    logic [8:0] pll_out_en;
    logic [7:0] osc_rdy_raw;
    logic [4:0] osc_clk_raw;
    logic [1:0] s;
    sccl_pkg::sccl_osc_type osc_ctl;
    sccl_pkg::sccl_src_type sys_src_sel;
    int num_errors = 0;
    int cmp_count = 0;
    int seed = 32'h192A8702;
    int c [5];
    int unsigned mdl [int];
    logic [7:0] ofs [4] = '{sccl_pkg::OFS_TRIM, sccl_pkg::OFS_KSEL, sccl_pkg::OFS_GRUN, sccl_pkg::OFS_GSLP};
    logic [31:0] msk [4] = '{32'h000F_FFF7, 32'h0000_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF};

    always #2.5 sys_clk = ~sys_clk;

    sccl_clock_ctrl #(.LSE_LOSS_CYC(300)) dut_u (
        .sys_clk, .srst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout),
        .hreadyout, .hresp, .hrdata, .osc_rdy_raw, .osc_clk_raw, .low_power, .vbat_only, .osc_ctl,
        .osc_trim(), .pll_src(), .pll_on, .pll_out_en, .sys_src_sel, .sys_gate_en, .cpu_tick,
        .apb1_tick, .apb2_tick, .kclk_sel(), .clk_gate_en, .mco_out, .slow_clock_output_out, .clk_irq
    );
    sccl_osc_model #(.RDY_NS(300)) osc_u (.hse_stop, .ctl(osc_ctl), .pll_on, .clk(osc_clk_raw), .rdy(osc_rdy_raw));

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic wait_rdy();
        int n;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1) begin
            num_errors++;
            tally_and_finish();
        end
    endtask

    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
    endtask

    task automatic measure(input int n);
        logic pm;
        logic pl;
        c = '{default: 0};
        pm = mco_out;
        pl = slow_clock_output_out;
        repeat (n) begin
            @(posedge sys_clk);
            c[0] += cpu_tick;
            c[1] += apb1_tick;
            c[2] += apb2_tick;
            c[3] += (mco_out != pm);
            c[4] += (slow_clock_output_out != pl);
            pm = mco_out;
            pl = slow_clock_output_out;
        end
    endtask

    initial begin
        repeat (8) @(posedge sys_clk);
        srst <= 1'b0;
        @(posedge sys_clk);
        chk("source", 32'h0, sys_src_sel);
        chk("osc_ctl", 32'h008, osc_ctl);
        $display("test reset done");
        foreach (ofs[i]) begin
            wv = $random(seed) & msk[i];
            mdl[ofs[i]] = wv;
            bus(ofs[i], 1'b1, wv);
            bus(ofs[i], 1'b0, 32'h0);
            chk("register", mdl[ofs[i]], rd);
        end
        bus(8'h40, 1'b1, wv);
        bus(8'h40, 1'b0, 32'h0);
        chk("unmapped", 32'h0, rd);
        chk("run_gate", mdl[sccl_pkg::OFS_GRUN], clk_gate_en);
        low_power <= 1'b1;
        repeat (2) @(posedge sys_clk);
        chk("sleep_gate", mdl[sccl_pkg::OFS_GSLP], clk_gate_en);
        $display("test registers done");
        bus(sccl_pkg::OFS_OSC, 1'b1, 32'h40D);
        bus(sccl_pkg::OFS_PLL, 1'b1, 32'h25);
        for (int i = 0; i < 4; i++) begin
            s = 2'((3 * i + 1) % 4);
            // CPU ratio 4, first bus 2 more, second bus none
            bus(sccl_pkg::OFS_CFG, 1'b1, 32'h0000_0028 | 32'(s));
            for (int n = 0; n < 600 && sys_src_sel !== s; n++) @(posedge sys_clk);
            chk("switched", s, sys_src_sel);
            bus(sccl_pkg::OFS_STAT, 1'b0, 32'h0);
            chk("status", s, rd[9:8]);
        end
        measure(64);
        chk("cpu_ticks", 16, c[0]);
        chk("apb1_ticks", 8, c[1]);
        chk("apb2_ticks", 16, c[2]);
        $display("test switch done");
        hse_stop <= 1'b1;
        for (int n = 0; n < 600 && sys_src_sel !== sccl_pkg::SRC_HSI; n++) @(posedge sys_clk);
        chk("fallback", sccl_pkg::SRC_HSI, sys_src_sel);
        bus(sccl_pkg::OFS_INT, 1'b0, 32'h0);
        chk("flag", 32'h1, rd[1:0]);
        chk("irq_masked", 32'h0, clk_irq);
        bus(sccl_pkg::OFS_INT, 1'b1, 32'h4);
        repeat (2) @(posedge sys_clk);
        chk("irq_on", 32'h1, clk_irq);
        bus(sccl_pkg::OFS_INT, 1'b1, 32'h5);
        repeat (2) @(posedge sys_clk);
        chk("irq_clear", 32'h0, clk_irq);
        $display("test monitor done");
        bus(sccl_pkg::OFS_OSC, 1'b1, 32'h10C);
        bus(sccl_pkg::OFS_CFG, 1'b1, 32'h9001);
        measure(600);
        chk("mco_runs", 32'h1, c[3] > 0);
        chk("slow_clock_output_runs", 32'h1, c[4] > 0);
        vbat_only <= 1'b1;
        measure(600);
        chk("slow_clock_output_stops", 32'h0, c[4] > 1);
        $display("test outputs done");
        tally_and_finish();
    end
endmodule

bind sccl_clock_ctrl sccl_clock_ctrl_sva chk_u (.sys_clk, .srst, .hsel, .htrans, .hwrite, .hready, .hreadyout,
    .hrdata, .osc_rdy_raw, .vbat_only, .pll_on, .pll_out_en, .sys_src_sel, .sys_gate_en, .slow_clock_output_out);
